//--- design/tcwu_consts.svh
`ifndef TCWU_CONSTS_SVH
`define TCWU_CONSTS_SVH
`define TCWU_ADDR_CTRL 4'h0
`define TCWU_ADDR_CNT 4'h4
`define TCWU_ADDR_CMP 4'h8
`define TCWU_ADDR_FLAG 4'hc
`define TCWU_ADDR_PORT 5'h10
`define TCWU_CTRL_FORCE 7
`define TCWU_CTRL_WGM_HI 6
`define TCWU_CTRL_COM_HI 5
`define TCWU_CTRL_COM_LO 4
`define TCWU_CTRL_WGM_LO 3
`define TCWU_FLAG_OVF 0
`define TCWU_FLAG_CMP 1
`define TCWU_PORT_DATA 0
`define TCWU_PORT_DIR 1
`define TCWU_CNT_MAX 8'hff
`define TCWU_CNT_BOTTOM 8'h00
`define TCWU_RST_LATCH 1'b0
`endif

//--- design/tcwu_pkg.sv
package tcwu_pkg;
   typedef enum logic [1:0] {
      TCWU_NORMAL,
      TCWU_PHASE,
      TCWU_CLEAR_ON_MATCH,
      TCWU_FAST_PWM
   } tcwu_wave_t;
   typedef enum logic [1:0] {
      TCWU_COM_OFF,
      TCWU_COM_TOGGLE,
      TCWU_COM_CLEAR,
      TCWU_COM_SET
   } tcwu_com_t;
endpackage

//--- design/tcwu_timer.sv
`timescale 1ns/1ps
`include "tcwu_consts.svh"
module tcwu_timer (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic timerTick,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic pinOut,
   output logic pinOe,
   output logic compareOutputLatch,
   output logic overflowFlag,
   output logic compareFlag
);
   logic [1:0] waveMode_r;
   logic [1:0] outMode_r;
   logic [7:0] counter_r;
   logic [7:0] compareValue_r;
   logic [7:0] compareBuf_r;
   logic latch_r;
   logic ovf_r;
   logic cmpf_r;
   logic portData_r;
   logic portDir_r;
   logic block_r;
   logic matchPend_r;
   logic ack_r;
   logic err_r;
   logic [31:0] rdata_r;
   logic pinOut_r;
   logic pinOe_r;

   wire req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
   wire lane0 = wb_sel_i[0];
   wire [7:0] wbyte = wb_dat_i[7:0];
   wire selCtrl = wb_adr_i[4:0] == {1'b0, `TCWU_ADDR_CTRL};
   wire selCnt = wb_adr_i[4:0] == {1'b0, `TCWU_ADDR_CNT};
   wire selCmp = wb_adr_i[4:0] == {1'b0, `TCWU_ADDR_CMP};
   wire selFlag = wb_adr_i[4:0] == {1'b0, `TCWU_ADDR_FLAG};
   wire selPort = wb_adr_i[4:0] == `TCWU_ADDR_PORT;
   wire mapped = (selCtrl | selCnt | selCmp | selFlag | selPort) & (wb_adr_i[31:5] == 27'h0);
   wire wrEn = req & mapped & wb_we_i & lane0;
   wire wrCtrl = wrEn & selCtrl;
   wire wrCnt = wrEn & selCnt;
   wire wrCmp = wrEn & selCmp;
   wire wrFlag = wrEn & selFlag;
   wire wrPort = wrEn & selPort;

   wire isNormal = waveMode_r == tcwu_pkg::TCWU_NORMAL;
   wire isClr = waveMode_r == tcwu_pkg::TCWU_CLEAR_ON_MATCH;
   wire isFast = waveMode_r == tcwu_pkg::TCWU_FAST_PWM;
   wire isPwm = waveMode_r[0];
   wire atMax = counter_r == `TCWU_CNT_MAX;
   // comparator sees the active register; match is blocked after a counter write
   wire rawMatch = counter_r == compareValue_r;
   wire match = rawMatch & ~block_r;
   wire tickMatch = timerTick & match;
   // counter sequence depends on waveform mode and, in clear-on-match, on the compare match
   wire clrOnMatch = isClr & match;
   wire wrapToBottom = atMax | clrOnMatch;
   wire [7:0] cntNext = wrapToBottom ? `TCWU_CNT_BOTTOM : counter_r + 8'h01;
   // overflow on max to bottom in normal, clear-on-match and fast pwm
   wire ovfEvent = timerTick & atMax & (isNormal | isClr | isFast);
   wire bottomEvent = timerTick & isFast & atMax;
   // compare at max in fast pwm with clear or set mode: match ignored, only bottom action, so level stays
   wire pwmMatchOk = ~(compareValue_r == `TCWU_CNT_MAX && outMode_r[1]);
   // strobe written with a new mode acts with that new mode, not the old one
   wire forceNow = wrCtrl & wbyte[`TCWU_CTRL_FORCE] & ~wbyte[`TCWU_CTRL_WGM_LO];
   wire [1:0] actMode = forceNow ? wbyte[`TCWU_CTRL_COM_HI:`TCWU_CTRL_COM_LO] : outMode_r;

   logic latchNxt;
   always_comb begin
      latchNxt = latch_r;
      if (forceNow | tickMatch & ~isPwm) begin
         case (actMode)
            tcwu_pkg::TCWU_COM_TOGGLE: latchNxt = ~latch_r;
            tcwu_pkg::TCWU_COM_CLEAR: latchNxt = 1'b0;
            tcwu_pkg::TCWU_COM_SET: latchNxt = 1'b1;
            default: latchNxt = latch_r;
         endcase
      end else if (isFast & tickMatch & pwmMatchOk) begin
         case (outMode_r)
            tcwu_pkg::TCWU_COM_TOGGLE: latchNxt = ~latch_r;
            tcwu_pkg::TCWU_COM_CLEAR: latchNxt = 1'b0;
            tcwu_pkg::TCWU_COM_SET: latchNxt = 1'b1;
            default: latchNxt = latch_r;
         endcase
      end else if (bottomEvent) begin
         case (outMode_r)
            tcwu_pkg::TCWU_COM_CLEAR: latchNxt = 1'b1;
            tcwu_pkg::TCWU_COM_SET: latchNxt = 1'b0;
            default: latchNxt = latch_r;
         endcase
      end
   end

   // bottom spike with compare at zero: set at bottom, cleared on the match one tick later
   wire [31:0] rdataNxt = selCtrl ? {24'h0, 1'b0, waveMode_r[1], outMode_r, waveMode_r[0], 3'h0} :
      selCnt ? {24'h0, counter_r} :
      selCmp ? {24'h0, isPwm ? compareBuf_r : compareValue_r} :
      selFlag ? {30'h0, cmpf_r, ovf_r} :
      selPort ? {30'h0, portDir_r, portData_r} : 32'h0;
   wire ovfClr = wrFlag & wbyte[`TCWU_FLAG_OVF];
   wire cmpClr = wrFlag & wbyte[`TCWU_FLAG_CMP];
   wire cmpSet = matchPend_r & timerTick;
   // a pending match is counted per tick; set beats clear
   wire pendNxt = timerTick ? tickMatch : matchPend_r | tickMatch;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         waveMode_r <= 2'h0;
         outMode_r <= 2'h0;
         portData_r <= 1'b0;
         portDir_r <= 1'b0;
      end else begin
         if (wrCtrl) begin
            waveMode_r <= {wbyte[`TCWU_CTRL_WGM_HI], wbyte[`TCWU_CTRL_WGM_LO]};
            outMode_r <= wbyte[`TCWU_CTRL_COM_HI:`TCWU_CTRL_COM_LO];
         end
         if (wrPort) begin
            portData_r <= wbyte[`TCWU_PORT_DATA];
            portDir_r <= wbyte[`TCWU_PORT_DIR];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         counter_r <= 8'h00;
         block_r <= 1'b0;
      end else begin
         if (wrCnt) begin
            counter_r <= wbyte;
         end else if (timerTick) begin
            counter_r <= cntNext;
         end
         // block holds until one timer tick has passed after the write
         if (wrCnt) begin
            block_r <= 1'b1;
         end else if (timerTick) begin
            block_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         compareValue_r <= 8'h00;
         compareBuf_r <= 8'h00;
      end else begin
         if (wrCmp) begin
            compareBuf_r <= wbyte;
         end
         if (wrCmp & ~isPwm) begin
            compareValue_r <= wbyte;
         end else if (isPwm & timerTick & atMax) begin
            compareValue_r <= compareBuf_r;
         end else if (!isPwm && !wrCmp && compareValue_r != compareBuf_r) begin
            compareValue_r <= compareValue_r;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         latch_r <= `TCWU_RST_LATCH;
         ovf_r <= 1'b0;
         cmpf_r <= 1'b0;
         matchPend_r <= 1'b0;
      end else begin
         latch_r <= latchNxt;
         ovf_r <= ovfEvent | ovf_r & ~ovfClr;
         cmpf_r <= cmpSet | cmpf_r & ~cmpClr;
         matchPend_r <= pendNxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
         rdata_r <= 32'h0;
         pinOut_r <= 1'b0;
         pinOe_r <= 1'b0;
      end else begin
         ack_r <= req & mapped;
         err_r <= req & ~mapped;
         rdata_r <= rdataNxt;
         // override from mode field alone, direction stays with the port
         pinOut_r <= (|outMode_r) ? latchNxt : portData_r;
         pinOe_r <= portDir_r;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign wb_dat_o = rdata_r;
   assign pinOut = pinOut_r;
   assign pinOe = pinOe_r;
   assign compareOutputLatch = latch_r;
   assign overflowFlag = ovf_r;
   assign compareFlag = cmpf_r;
endmodule

//--- dv/tcwu_timer_checker.sv
`timescale 1ns/1ps
module tcwu_timer_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic timerTick,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic pinOut,
   input wire logic compareOutputLatch,
   input wire logic overflowFlag,
   input wire logic compareFlag
);
   logic [1:0] comMode_r;
   wire req = wb_cyc_i && wb_stb_i;
   wire wr = req && wb_we_i && !wb_ack_o && wb_sel_i[0];
   wire ctlWr = wr && wb_adr_i == 32'h0;
   wire flgWr = wr && wb_adr_i == 32'hc;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         comMode_r <= 2'h0;
      end else if (ctlWr) begin
         comMode_r <= wb_dat_i[5:4];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // tick held idle, else a real match could act at the same edge
   sequence force_s(c);
      ctlWr && !timerTick && wb_dat_i[7] && !wb_dat_i[3] && wb_dat_i[5:4] == c;
   endsequence
   rstClr_a: assert property ($rose(rst_n) |-> !compareOutputLatch && !overflowFlag)
      else $error("state not cleared");
   tickOnly_a: assert property (!timerTick && !req |=>
      $stable({compareOutputLatch, overflowFlag, compareFlag})) else $error("moved off tick");
   pinSrc_a: assert property (comMode_r != 2'h0 && $stable(comMode_r) |->
      pinOut == compareOutputLatch) else $error("pin not from latch");
   forceSet_a: assert property (force_s(2'h3) |=> compareOutputLatch)
      else $error("force set");
   forceClr_a: assert property (force_s(2'h2) |=> !compareOutputLatch)
      else $error("force clear");
   forceTgl_a: assert property (force_s(2'h1) |=> $changed(compareOutputLatch))
      else $error("force toggle");
   modeZero_a: assert property (comMode_r == 2'h0 && !ctlWr |=>
      $stable(compareOutputLatch)) else $error("latch moved in mode 0");
   cmpClr_a: assert property (flgWr && wb_dat_i[1] && !timerTick |=> !compareFlag)
      else $error("compare flag kept");
   ovfKeep_a: assert property (!(flgWr && wb_dat_i[0]) |=> !$fell(overflowFlag))
      else $error("overflow flag lost");
endmodule

//--- dv/tcwu_pin_model.sv
`timescale 1ns/1ps
module tcwu_pin_model (
   input wire logic pinOut,
   input wire logic pinOe,
   output logic pinLevel
);
   // released pin goes to its pull-up, never keeps the last driven value
   assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic timerTick = 1'b0;
   logic [31:0] wb_adr_i = 32'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h1;
   logic wb_we_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, wb_err_o, pinOut, pinOe, compareOutputLatch, overflowFlag, compareFlag;
   logic pinLevel, lastErr;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   tcwu_timer dut (.*);
   tcwu_pin_model pin (.*);
   initial forever #2.5 core_clk = ~core_clk;
   task automatic end_of_test();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic w);
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_we_i <= w;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      @(posedge core_clk);
      while (!(wb_ack_o || wb_err_o)) @(posedge core_clk);
      rd = wb_dat_o;
      lastErr = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         timerTick <= 1'b1;
         @(posedge core_clk);
         timerTick <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   // order: overflow, compare flag, latch, pin level
   task automatic st(input logic [3:0] e);
      check({28'h0, overflowFlag, compareFlag, compareOutputLatch, pinLevel}, {28'h0, e});
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      st(4'h1);
      bus(32'h10, 32'h2, 1'b1);
      st(4'h0);
      bus(32'h0, 32'hb0, 1'b1);
      st(4'h3);
      bus(32'h0, 32'ha0, 1'b1);
      st(4'h0);
      bus(32'h0, 32'h90, 1'b1);
      st(4'h3);
      bus(32'h8, 32'h5, 1'b1);
      bus(32'h4, 32'hfd, 1'b1);
      bus(32'h0, 32'h10, 1'b1);
      ticks(2);
      st(4'h3);
      ticks(1);
      st(4'hb);
      ticks(7);
      st(4'hc);
      bus(32'h4, 32'h0, 1'b0);
      check(rd, 32'h7);
      bus(32'hc, 32'h3, 1'b1);
      bus(32'hc, 32'h0, 1'b0);
      check(rd, 32'h0);
      bus(32'h0, 32'h50, 1'b1);
      bus(32'h8, 32'h3, 1'b1);
      bus(32'h4, 32'h0, 1'b1);
      ticks(5);
      st(4'h7);
      bus(32'h4, 32'h0, 1'b0);
      check(rd, 32'h1);
      bus(32'hc, 32'h3, 1'b1);
      bus(32'h8, 32'h0, 1'b1);
      ticks(254);
      bus(32'hc, 32'h0, 1'b0);
      check(rd, 32'h0);
      ticks(1);
      bus(32'hc, 32'h0, 1'b0);
      check(rd, 32'h1);
      bus(32'h0, 32'h68, 1'b1);
      bus(32'h8, 32'h10, 1'b1);
      bus(32'hc, 32'h3, 1'b1);
      bus(32'h4, 32'hfe, 1'b1);
      ticks(3);
      st(4'hb);
      bus(32'h4, 32'h0, 1'b0);
      check(rd, 32'h1);
      ticks(17);
      st(4'hc);
      bus(32'h0, 32'h78, 1'b1);
      ticks(238);
      st(4'hc);
      ticks(17);
      st(4'hf);
      bus(32'h20, 32'h0, 1'b0);
      check({31'h0, lastErr}, 32'h1);
      end_of_test();
   end
endmodule
bind tcwu_timer tcwu_timer_checker chk (.*);
